// ---- core/rsg_pkg.sv ----
// Purpose: Shared constants and types for the RS-485 send-gate block
// Assumes: 10 MHz module clock, 8-bit characters
// Notes:   All offsets, counts and encodings live here
package rsg_pkg;

   // ------------------------------------------------------------
   // Clock and character framing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 100;     // Module clock period
   localparam int unsigned DATA_BITS      = 8;       // Data bits per char
   localparam int unsigned CHAR_BITS      = 11;      // Start+8+parity+stop
   localparam int unsigned IDLE_CHARS     = 2;       // Least mark lead-in
   localparam int unsigned IDLE_BITS      = IDLE_CHARS * CHAR_BITS;

   // ------------------------------------------------------------
   // Bit-rate selection
   // ------------------------------------------------------------
   localparam int unsigned RATE_W         = 2;       // Rate select width
   localparam int unsigned NUM_RATES      = 4;       // Supported rates
   localparam int unsigned DIV_W          = 16;      // Divider width
   localparam int unsigned HOLD_W         = 8;       // Hold count width
   // Bit periods in clocks: 9600, 19200, 38400, 115200 baud at 10 MHz
   localparam logic [DIV_W-1:0] BIT_DIV [NUM_RATES] = '{
      16'h0411, 16'h0208, 16'h0104, 16'h0056};
   // Gate-off hold, in bit periods, per rate
   localparam logic [HOLD_W-1:0] HOLD_BITS [NUM_RATES] = '{
      8'h01, 8'h01, 8'h02, 8'h04};

   // ------------------------------------------------------------
   // Head-character selection
   // ------------------------------------------------------------
   localparam logic [7:0] HEAD_ENQ = 8'h05;          // ASCII frame head
   localparam logic [7:0] HEAD_STX = 8'h02;          // Alternate ASCII
   localparam logic [7:0] HEAD_DLE = 8'h10;          // Binary frame head

   // Protocol mode of the receive filter
   typedef enum logic [1:0] {
      RSG_MODE_NONE = 2'b00,                         // No head filtering
      RSG_MODE_PLC  = 2'b01,                         // PLC access frames
      RSG_MODE_USER = 2'b11                          // Registered frame
   } rsg_mode_t;

   // Transmit gate states, Gray coded along the usual path
   typedef enum logic [1:0] {
      RSG_TX_OFF  = 2'b00,                           // Driver high-Z
      RSG_TX_LEAD = 2'b01,                           // Mark lead-in
      RSG_TX_DATA = 2'b11,                           // Sending chars
      RSG_TX_HOLD = 2'b10                            // Gate-off hold
   } rsg_tx_state_t;

endpackage

// ---- core/rsg_buf_if.sv ----
// Purpose: Valid/ready carrier for the two-entry character buffer
// Assumes: One byte per transfer
// Notes:   Used between the top module and its buffer
`timescale 1ns/1ps
`default_nettype none
interface rsg_buf_if;
   logic       valid;                                // Word offered
   logic       ready;                                // Word accepted
   logic [7:0] data;                                 // Character
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- core/rsg_buf.sv ----
// Purpose: Two-entry skid buffer for transmit characters
// Assumes: Single clock, synchronous reset
// Notes:   Full and empty are exact; ready reflects free space
`timescale 1ns/1ps
`default_nettype none
module rsg_buf
   import rsg_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Filling and draining sides
   rsg_buf_if.snk    in_if,
   rsg_buf_if.src    out_if
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] mem_q [2];                            // Two entries
   logic       wr_q;                                 // Write index
   logic       rd_q;                                 // Read index
   logic [1:0] cnt_q;                                // Entries held
   logic       push;                                 // Word stored
   logic       pop;                                  // Word drained

   assign in_if.ready  = (cnt_q != 2'd2);
   assign out_if.valid = (cnt_q != 2'd0);
   assign out_if.data  = mem_q[rd_q];
   assign push = in_if.valid && in_if.ready;
   assign pop  = out_if.valid && out_if.ready;

   // Write the entry at the write index
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_if.data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'd0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= ~wr_q;
         end
         if (pop)
         begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule
`default_nettype wire

// ---- core/rsg_top.sv ----
// Purpose: RS-485 send-gate control with noise-filtering receiver
// Assumes: 8 data bits, even parity, 1 stop bit; inputs synchronous
// Notes:   Driver enable frames each burst with lead-in and hold
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Idle bus floats; tolerate noise characters
// - Drop characters with parity or framing error
// - Ignore characters before expected head character
// - PLC access head set by frame format
// - User frame head from registered definition
// - Gate on drives send pair low impedance
// - Gate off leaves send pair high-Z
// - Send two characters of mark first
// - Hold gate after last char, then done
module rsg_top
   import rsg_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK_I,
   input  wire logic       RESET_I,
   // Configuration
   input  wire logic [1:0] RATE_SEL_I,
   input  wire logic [1:0] MODE_I,
   input  wire logic [1:0] PLC_FORMAT_I,
   input  wire logic [7:0] USER_HEAD_I,
   // Transmit character stream
   input  wire logic       TX_VALID_I,
   input  wire logic [7:0] TX_DATA_I,
   output logic            TX_READY_O,
   output logic            TX_DONE_O,
   // Receive character stream
   output logic            RX_VALID_O,
   output logic [7:0]      RX_DATA_O,
   output logic            RX_DROP_O,
   // Line pins
   output logic            SEND_PAIR_O,
   output logic            SEND_PAIR_OE_O,
   input  wire logic       RECEIVE_PAIR_I
);

   // ------------------------------------------------------------
   // Rate selection
   // ------------------------------------------------------------
   logic [DIV_W-1:0]  bit_div;                       // Clocks per bit
   logic [HOLD_W-1:0] hold_bits;                     // Hold length

   assign bit_div   = BIT_DIV[RATE_SEL_I];
   assign hold_bits = HOLD_BITS[RATE_SEL_I];

   // ------------------------------------------------------------
   // Transmit buffer
   // ------------------------------------------------------------
   rsg_buf_if in_bus ();
   rsg_buf_if out_bus ();

   assign in_bus.valid = TX_VALID_I;
   assign in_bus.data  = TX_DATA_I;
   assign TX_READY_O   = in_bus.ready;

   rsg_buf u_buf (
      .clk_i  (CLK_I),
      .rst_i  (RESET_I),
      .in_if  (in_bus),
      .out_if (out_bus)
   );

   // ------------------------------------------------------------
   // Transmit state
   // ------------------------------------------------------------
   rsg_tx_state_t    tx_state_q;                     // Gate state
   logic [DIV_W-1:0] tx_div_q;                       // Bit timer
   logic [4:0]       tx_bits_q;                      // Bits left
   logic [10:0]      tx_shift_q;                     // Frame shifter
   logic             tx_busy_q;                      // Char in flight
   logic             tx_tick;                        // Bit boundary
   logic             tx_load;                        // Take next char
   logic             done_q;                         // Done pulse
   logic             line_q;                         // Driven level

   assign tx_tick = (tx_div_q == '0);
   assign tx_load = (tx_state_q == RSG_TX_DATA) && !tx_busy_q
                    && out_bus.valid && tx_tick;
   assign out_bus.ready = tx_load;

   // Bit timer runs whenever the gate is on
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || tx_state_q == RSG_TX_OFF || tx_tick)
      begin
         tx_div_q <= bit_div - 16'h0001;
      end
      else
      begin
         tx_div_q <= tx_div_q - 16'h0001;
      end
   end

   // Gate state machine: lead-in, data, hold
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         tx_state_q <= RSG_TX_OFF;
         tx_bits_q  <= 5'd0;
         done_q     <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (tx_state_q)
            RSG_TX_OFF:
            begin
               // Enable only when there is something to send
               if (out_bus.valid)
               begin
                  tx_state_q <= RSG_TX_LEAD;
                  tx_bits_q  <= 5'(IDLE_BITS);
               end
            end
            RSG_TX_LEAD:
            begin
               if (tx_tick)
               begin
                  if (tx_bits_q == 5'd1)
                  begin
                     tx_state_q <= RSG_TX_DATA;
                  end
                  tx_bits_q <= tx_bits_q - 5'd1;
               end
            end
            RSG_TX_DATA:
            begin
               // Last char fully shifted and nothing queued
               if (tx_tick && !tx_busy_q && !out_bus.valid)
               begin
                  tx_state_q <= RSG_TX_HOLD;
                  tx_bits_q  <= hold_bits[4:0];
               end
            end
            RSG_TX_HOLD:
            begin
               if (tx_tick)
               begin
                  if (tx_bits_q <= 5'd1)
                  begin
                     tx_state_q <= RSG_TX_OFF;
                     done_q     <= 1'b1;
                  end
                  tx_bits_q <= tx_bits_q - 5'd1;
               end
            end
            default:
            begin
               tx_state_q <= RSG_TX_OFF;
            end
         endcase
      end
   end

   // Character shifter: start, data LSB first, even parity, stop
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         tx_shift_q <= 11'h7FF;
         tx_busy_q  <= 1'b0;
         line_q     <= 1'b1;
      end
      else if (tx_load)
      begin
         tx_shift_q <= {1'b1, ^out_bus.data, out_bus.data, 1'b0};
         tx_busy_q  <= 1'b1;
         line_q     <= 1'b1;
      end
      else if (tx_tick && tx_state_q == RSG_TX_DATA && tx_busy_q)
      begin
         // Zeros fill from the top, so the stop bit is the last one set;
         // trailing ones in the data cannot end the character early
         line_q     <= tx_shift_q[0];
         tx_shift_q <= {1'b0, tx_shift_q[10:1]};
         tx_busy_q  <= (tx_shift_q[10:1] != 10'h000);
      end
      else if (tx_state_q != RSG_TX_DATA)
      begin
         line_q <= 1'b1;
      end
   end

   // Driver enable follows the gate state
   assign SEND_PAIR_OE_O = (tx_state_q != RSG_TX_OFF);
   assign SEND_PAIR_O    = line_q;
   assign TX_DONE_O      = done_q;

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   logic [DIV_W-1:0] rx_div_q;                       // Sample timer
   logic [3:0]       rx_cnt_q;                       // Bit index
   logic             rx_busy_q;                      // In a frame
   logic [9:0]       rx_shift_q;                     // Data,parity,stop
   logic             rx_end;                         // Frame complete
   logic             rx_ok;                          // No errors
   logic             hunt_q;                         // Awaiting head
   logic [7:0]       head_char;                      // Expected head
   logic [7:0]       rx_byte;                        // Received data

   // Expected head by mode and format
   always_comb
   begin
      head_char = HEAD_ENQ;
      if (MODE_I == RSG_MODE_USER)
      begin
         head_char = USER_HEAD_I;
      end
      else if (PLC_FORMAT_I == 2'd1)
      begin
         head_char = HEAD_STX;
      end
      else if (PLC_FORMAT_I == 2'd2)
      begin
         head_char = HEAD_DLE;
      end
   end

   assign rx_end  = rx_busy_q && rx_div_q == '0 && rx_cnt_q == 4'd10;
   // At frame end nine samples are held; the stop bit is still on the pin
   assign rx_byte = rx_shift_q[8:1];
   // Noise on a floating line shows up as bad parity or stop
   assign rx_ok   = RECEIVE_PAIR_I && (^rx_shift_q[9:1] == 1'b0);

   // Bit sampler, mid-bit after a falling start edge
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         rx_busy_q  <= 1'b0;
         rx_div_q   <= '0;
         rx_cnt_q   <= 4'd0;
         rx_shift_q <= 10'h000;
      end
      else if (!rx_busy_q)
      begin
         if (!RECEIVE_PAIR_I)
         begin
            rx_busy_q <= 1'b1;
            rx_cnt_q  <= 4'd0;
            rx_div_q  <= {1'b0, bit_div[DIV_W-1:1]};
         end
      end
      else if (rx_div_q != '0)
      begin
         rx_div_q <= rx_div_q - 16'h0001;
      end
      else
      begin
         rx_div_q <= bit_div - 16'h0001;
         if (rx_cnt_q == 4'd0 && RECEIVE_PAIR_I)
         begin
            rx_busy_q <= 1'b0;
         end
         else if (rx_cnt_q == 4'd10)
         begin
            rx_busy_q <= 1'b0;
         end
         else
         begin
            rx_cnt_q <= rx_cnt_q + 4'd1;
         end
         if (rx_cnt_q != 4'd0 && rx_cnt_q != 4'd10)
         begin
            rx_shift_q <= {RECEIVE_PAIR_I, rx_shift_q[9:1]};
         end
         else if (rx_cnt_q == 4'd10)
         begin
            rx_shift_q <= {RECEIVE_PAIR_I, rx_shift_q[9:1]};
         end
      end
   end

   // Head filter and delivery
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         hunt_q     <= 1'b1;
         RX_VALID_O <= 1'b0;
         RX_DROP_O  <= 1'b0;
         RX_DATA_O  <= 8'h00;
      end
      else
      begin
         RX_VALID_O <= 1'b0;
         RX_DROP_O  <= 1'b0;
         if (tx_state_q == RSG_TX_HOLD && done_q == 1'b0
             && MODE_I != RSG_MODE_NONE)
         begin
            hunt_q <= 1'b1;
         end
         if (rx_end)
         begin
            if (!rx_ok)
            begin
               RX_DROP_O <= 1'b1;
            end
            else if (MODE_I != RSG_MODE_NONE && hunt_q
                     && rx_byte != head_char)
            begin
               RX_DROP_O <= 1'b1;
            end
            else
            begin
               hunt_q     <= 1'b0;
               RX_VALID_O <= 1'b1;
               RX_DATA_O  <= rx_byte;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ---- tb/rsg_chk.sv ----
// Purpose: Port-level checks of the send-gate block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to rsg_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rsg_chk
(
   // Clock and reset
   input  wire logic CLK_I,
   input  wire logic RESET_I,
   // Watched ports
   input  wire logic TX_VALID_I,
   input  wire logic TX_READY_O,
   input  wire logic TX_DONE_O,
   input  wire logic RX_VALID_O,
   input  wire logic RX_DROP_O,
   input  wire logic SEND_PAIR_O,
   input  wire logic SEND_PAIR_OE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   // ----------------------------------------
   // Send gate
   // ----------------------------------------
   chk_reset_gate_off: assert property (disable iff (1'b0)
      RESET_I |=> !SEND_PAIR_OE_O && !TX_DONE_O)
      else $error("gate or done active after reset");
   chk_off_line_mark: assert property (
      !SEND_PAIR_OE_O |-> SEND_PAIR_O)
      else $error("line not at mark while released");
   chk_lead_mark: assert property (
      $rose(SEND_PAIR_OE_O) |-> SEND_PAIR_O [*8])
      else $error("no mark right after gate opens");
   chk_gate_opens: assert property (
      TX_VALID_I && TX_READY_O && !SEND_PAIR_OE_O
         |-> ##[1:3] SEND_PAIR_OE_O)
      else $error("gate not opened for a taken character");
   chk_done_at_off: assert property (
      TX_DONE_O |-> $fell(SEND_PAIR_OE_O))
      else $error("done without gate falling");
   chk_off_gives_done: assert property (
      $fell(SEND_PAIR_OE_O) |-> TX_DONE_O)
      else $error("gate fell without done");
   chk_done_one_cycle: assert property (
      TX_DONE_O |=> !TX_DONE_O)
      else $error("done longer than one cycle");

   // ----------------------------------------
   // Receive results
   // ----------------------------------------
   chk_rx_exclusive: assert property (
      !(RX_VALID_O && RX_DROP_O))
      else $error("character both passed and dropped");
   chk_rx_one_result: assert property (
      RX_VALID_O || RX_DROP_O |=> !(RX_VALID_O || RX_DROP_O) [*8])
      else $error("two results for one character");

   cover property ($rose(SEND_PAIR_OE_O));
   cover property (TX_DONE_O);
   cover property (RX_VALID_O);
   cover property (RX_DROP_O);
endmodule
`default_nettype wire

// ---- tb/rsg_station.sv ----
// Purpose: Far station on the shared pairs
// Assumes: 8E1 characters, bit length given in clocks
// Notes:   Releases the pair to a pull-up when silent
`timescale 1ns/1ps
`default_nettype none
module rsg_station
   import rsg_pkg::*;
(
   // Clock and bit length
   input  wire logic        clk_i,
   input  wire logic [15:0] div_i,
   // Block's send pair
   input  wire logic        line_i,
   input  wire logic        line_oe_i,
   // Our drive onto the block's receive pair
   output logic             rx_o
);
   logic       drv_en  = 1'b0;   // Driving the pair
   logic       drv_val = 1'b1;   // Level driven
   logic [7:0] got_q[$];         // Characters decoded
   logic       bad     = 1'b0;   // Parity or stop fault seen
   logic       first   = 1'b0;   // Next start is burst's first
   logic [9:0] sh;               // Data, parity, stop samples
   int         rises   = 0;      // Gate openings seen
   time        rise_t, fall_t, first_t, last_t;

   // Released pair is pulled up to mark
   assign rx_o = drv_en ? drv_val : 1'b1;

   // Send one character, optionally corrupted
   task send(input logic [7:0] b, input logic bp, input logic bs);
      logic [10:0] f;
      begin
         f = {~bs, (^b) ^ bp, b, 1'b0};
         @(posedge clk_i);
         #1;
         drv_en = 1'b1;
         for (int i = 0; i < 11; i++)
         begin
            drv_val = f[i];
            repeat (div_i) @(posedge clk_i);
            #1;
         end
         drv_en = 1'b0;
      end
   endtask

   // Gate edges
   always @(posedge line_oe_i)
   begin
      rise_t = $time;
      rises++;
      first = 1'b1;
   end
   always @(negedge line_oe_i) fall_t = $time;

   // Decode what the block sends while driving
   initial forever
   begin
      @(negedge line_i iff line_oe_i);
      last_t = $time;
      if (first) first_t = $time;
      first = 1'b0;
      repeat (div_i / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++)
      begin
         repeat (div_i) @(posedge clk_i);
         sh[i] = line_i;
      end
      if ((^sh[8:0]) !== 1'b0 || sh[9] !== 1'b1) bad = 1'b1;
      got_q.push_back(sh[7:0]);
   end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the send-gate block
// Assumes: Station model on the far side of the pairs
// Notes:   Receive cases from a table, bursts by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rsg_pkg::*;
   // Row: mode/fmt, user head, char, flags bp bs rearm pass
   typedef struct packed {
      logic [1:0] mode, fmt;
      logic [7:0] uh, ch;
      logic       bp, bs, rearm, ev;
   } rsg_row_t;
   rsg_row_t rows [14] = '{
      24'h00_0411, 24'h00_0418, 24'h00_0414,
      24'h40_0412, 24'h40_0051, 24'h40_0411,
      24'h50_0052, 24'h50_0021, 24'h60_0022,
      24'h60_0101, 24'h70_0053,
      24'hca_5052, 24'hca_5a51, 24'hca_5a5a};
   logic       clk = 1'b0, rst = 1'b1, txv = 1'b0, full;
   logic [1:0] rate = 2'h3, mode = 2'h0, fmt = 2'h0;
   logic [7:0] uh = 8'h00, txd = 8'h00, rxd, gd;
   logic       rdy, done, rxv, rxx, sp, spoe, rxl;
   int         bad_count = 0, n_checks = 0, nv, nx, nd;

   rsg_top i_rsg_top (.CLK_I(clk), .RESET_I(rst), .RATE_SEL_I(rate),
      .MODE_I(mode), .PLC_FORMAT_I(fmt), .USER_HEAD_I(uh),
      .TX_VALID_I(txv), .TX_DATA_I(txd), .TX_READY_O(rdy),
      .TX_DONE_O(done), .RX_VALID_O(rxv), .RX_DATA_O(rxd),
      .RX_DROP_O(rxx), .SEND_PAIR_O(sp), .SEND_PAIR_OE_O(spoe),
      .RECEIVE_PAIR_I(rxl));
   rsg_station i_rsg_station (.clk_i(clk), .div_i(BIT_DIV[rate]),
      .line_i(sp), .line_oe_i(spoe), .rx_o(rxl));

   always #50 clk = ~clk;

   // Count result pulses
   always @(posedge clk)
   begin
      if (rxv === 1'b1)
      begin
         nv++;
         gd = rxd;
      end
      if (rxx === 1'b1) nx++;
      if (done === 1'b1) nd++;
   end

   task check(input string what, input logic [31:0] seen, exp);
      begin
         n_checks++;
         if (seen !== exp)
         begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h",
                     what, exp, seen);
         end
      end
   endtask

   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // Offer one character and hold it until taken
   task put(input logic [7:0] b);
      begin
         txd = b;
         txv = 1'b1;
         @(posedge clk);
         for (int k = 0; k < 20000 && rdy !== 1'b1; k++)
         begin
            full = 1'b1;
            @(posedge clk);
         end
         #1;
      end
   endtask

   // Send n characters at rate r and check the whole burst
   task burst(input logic [1:0] r, input int n);
      int h, d;
      begin
         rate = r;
         d = BIT_DIV[r];
         i_rsg_station.got_q.delete();
         h = i_rsg_station.rises;
         nd = 0;
         full = 1'b0;
         @(posedge clk);
         #1;
         for (int i = 0; i < n; i++) put(8'h3c + 8'(i * 17));
         txv = 1'b0;
         for (int k = 0; k < (n * 11 + 40) * d && nd == 0; k++)
            @(posedge clk);
         repeat (2) @(posedge clk);
         #1;
         check("bursts", i_rsg_station.rises - h, 1);
         check("chars", i_rsg_station.got_q.size(), n);
         for (int i = 0; i < n; i++)
            check("char", i_rsg_station.got_q[i], 8'h3c + 8'(i * 17));
         check("parity", i_rsg_station.bad, 1'b0);
         check("done", nd, 1);
         check("gate", spoe, 1'b0);
         check("lead", (i_rsg_station.first_t - i_rsg_station.rise_t)
            / 100 >= IDLE_BITS * d, 1'b1);
         h = int'((i_rsg_station.fall_t - i_rsg_station.last_t) / 100)
            - 11 * d - HOLD_BITS[r] * d;
         check("hold", h >= -2 && h <= 2, 1'b1);
         if (n > 2) check("refused", full, 1'b1);
      end
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      #1;
      check("gate in reset", spoe, 1'b0);
      check("line in reset", sp, 1'b1);
      check("ready in reset", rdy, 1'b1);
      rst = 1'b0;
      for (int i = 0; i < 14; i++)
      begin
         @(posedge clk);
         #1;
         {mode, fmt} = {rows[i].mode, rows[i].fmt};
         uh = rows[i].uh;
         if (rows[i].rearm) burst(2'h3, 1);
         nv = 0;
         nx = 0;
         i_rsg_station.send(rows[i].ch, rows[i].bp, rows[i].bs);
         repeat (4) @(posedge clk);
         #1;
         check("rx valid", nv, rows[i].ev);
         check("rx drop", nx, !rows[i].ev);
         if (rows[i].ev) check("rx data", gd, rows[i].ch);
      end
      burst(2'h2, 4);
      burst(2'h1, 1);
      // Reset in mid-burst
      nd = 0;
      put(8'h55);
      txv = 1'b0;
      repeat (50) @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("gate after reset", spoe, 1'b0);
      check("ready after reset", rdy, 1'b1);
      rst = 1'b0;
      repeat (3000) @(posedge clk);
      check("no done", nd, 0);
      wrap_up;
   end

   // Watchdog
   initial
   begin
      #9000000;
      bad_count++;
      wrap_up;
   end
endmodule

bind rsg_top rsg_chk i_rsg_chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
   .TX_VALID_I(TX_VALID_I), .TX_READY_O(TX_READY_O),
   .TX_DONE_O(TX_DONE_O), .RX_VALID_O(RX_VALID_O),
   .RX_DROP_O(RX_DROP_O), .SEND_PAIR_O(SEND_PAIR_O),
   .SEND_PAIR_OE_O(SEND_PAIR_OE_O));
`default_nettype wire
